/* File: verilog/display_host_bus_decode.sv */
// module: host parallel bus port of the dot-matrix display controller
`timescale 1ns/1ns
`default_nettype none
module display_host_bus_decode
    import display_bus_pkg::*;
#(
    parameter int DIV = CLK_DIV // half period of exported master clock
) (
    input  wire logic              clk,                 // 25 MHz system clock
    input  wire logic              rst,                 // synchronous, active high
    input  wire logic              chip_select_n,       // host chip select
    input  wire logic              write_n,             // host write strobe
    input  wire logic              read_n,              // host read strobe
    input  wire logic              flash_select_n,      // flash ram select
    input  wire logic [ADDR_W-1:0] addr_lines,          // host address
    input  wire logic [DATA_W-1:0] data_in,             // data bus level
    output logic      [DATA_W-1:0] data_out,            // read data
    output logic                   data_oe,             // high while driving data
    input  wire logic              clock_source_select, // high: internal
    input  wire logic              master_clk_in,       // clock pin level
    output logic                   master_clk_out,      // clock pin drive
    output logic                   master_clk_oe,       // clock pin enable
    output logic                   master_tick          // one-cycle master clock edge
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        host_pins_t                     sync1;      // first synchroniser stage
        host_pins_t                     pins;       // second stage, used by logic
        logic [1:0]                     src_sync;   // clock select synchroniser
        logic [2:0]                     mclk_sync;  // two stages plus edge history
        logic [7:0]                     div_cnt;    // internal oscillator divider
        logic                           osc;        // internal master clock
        logic                           wr_done;    // one write per strobe
        logic [DATA_W-1:0]              glyph_addr; // user-glyph address register
        logic [DATA_W-1:0]              control;    // control word register
        logic [DEPTH-1:0][DATA_W-1:0]   char_ram;   // character codes
        logic [DEPTH-1:0][DATA_W-1:0]   flash_ram;  // flash bits per position
        logic [DEPTH-1:0][DATA_W-1:0]   glyph_ram;  // rows of current glyph
        logic [DATA_W-1:0]              dout;       // read data register
        logic                           doe;        // read drive enable
        logic                           mout;       // clock pin drive
        logic                           moe;        // clock pin enable
        logic                           tick;       // master clock rising edge
    } state_t;

    state_t  cur;
    state_t  next_cur;
    access_t acc;

    // decode from synchronised pins only
    section_decode section_decode_i (
        .flash_select_n (cur.pins.flash_select_n),
        .addr_lines     (cur.pins.addr_lines),
        .access         (acc)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    // read mux, used by the read path
    function automatic logic [DATA_W-1:0] read_word(input state_t s, input access_t a);
        unique case (a.section)
            MEM_FLASH:      read_word = s.flash_ram[a.loc];
            MEM_GLYPH_ADDR: read_word = s.glyph_addr;
            MEM_GLYPH_RAM:  read_word = s.glyph_ram[a.loc];
            MEM_CONTROL:    read_word = s.control;
            MEM_CHAR_RAM:   read_word = s.char_ram[a.loc];
            default:        read_word = RESET_DATA;
        endcase
    endfunction

    logic sel;      // chip select active
    logic rd_act;   // synced read strobe under select
    logic wr_act;   // synced write strobe under select
    logic int_src;  // internal master clock chosen
    assign sel     = !cur.pins.chip_select_n;
    assign rd_act  = sel && !cur.pins.read_n;
    assign wr_act  = sel && !cur.pins.write_n;
    assign int_src = cur.src_sync[1];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_cur = cur;
        // pins cross two flops before any logic sees them
        next_cur.sync1 = '{chip_select_n, write_n, read_n, flash_select_n, addr_lines, data_in};
        next_cur.pins  = cur.sync1;
        next_cur.src_sync  = {cur.src_sync[0], clock_source_select};
        next_cur.mclk_sync = {cur.mclk_sync[1:0], master_clk_in};

        // internal oscillator stand-in: divided system clock
        if (cur.div_cnt == 8'(DIV - 1)) begin
            next_cur.div_cnt = 8'h00;
            next_cur.osc     = !cur.osc;
        end else begin
            next_cur.div_cnt = cur.div_cnt + 8'h01;
        end

        // clock pin direction and master tick source
        next_cur.moe  = int_src;
        next_cur.mout = int_src && cur.osc;
        if (int_src) begin
            // internal source selected
            next_cur.tick = next_cur.osc && !cur.osc;
        end else begin
            // external clock from another display
            next_cur.tick = cur.mclk_sync[1] && !cur.mclk_sync[2];
        end

        // write: one store per strobe low period; strobe edge is the hazard
        if (wr_act && !cur.wr_done) begin
            next_cur.wr_done = 1'b1;
            unique case (acc.section)
                MEM_FLASH:      next_cur.flash_ram[acc.loc] = cur.pins.data;
                MEM_GLYPH_ADDR: next_cur.glyph_addr          = cur.pins.data;
                MEM_GLYPH_RAM:  next_cur.glyph_ram[acc.loc] = cur.pins.data;
                MEM_CONTROL:    next_cur.control             = cur.pins.data;
                MEM_CHAR_RAM:   next_cur.char_ram[acc.loc]  = cur.pins.data;
                default:        next_cur.wr_done             = 1'b1;
            endcase
        end else if (!wr_act) begin
            next_cur.wr_done = 1'b0;
        end

        // read: drive only while read and select both low
        next_cur.doe  = rd_act;
        next_cur.dout = rd_act ? read_word(cur, acc) : RESET_DATA;

        if (rst) begin
            next_cur = '0;
            next_cur.sync1.chip_select_n = 1'b1;
            next_cur.sync1.write_n       = 1'b1;
            next_cur.sync1.read_n        = 1'b1;
            next_cur.pins.chip_select_n  = 1'b1;
            next_cur.pins.write_n        = 1'b1;
            next_cur.pins.read_n         = 1'b1;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk) begin
        cur <= next_cur;
    end

    // outputs straight from flops; bus is split in/out/enable
    assign data_out       = cur.dout;
    assign data_oe        = cur.doe;
    assign master_clk_out = cur.mout;
    assign master_clk_oe  = cur.moe;
    assign master_tick    = cur.tick;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_read_req;
        !cur.pins.chip_select_n && !cur.pins.read_n;
    endsequence

    // first cycle of a write strobe; later cycles of the same strobe store nothing
    sequence s_write_first;
        !cur.pins.chip_select_n && !cur.pins.write_n && !cur.wr_done;
    endsequence

    AST_READ_DRIVES: assert property (s_read_req |=> data_oe)
        else $error("read not driven");
    AST_NO_DRIVE_IDLE: assert property (cur.pins.read_n |=> !data_oe)
        else $error("drive outside read");
    AST_NO_DRIVE_DESEL: assert property (cur.pins.chip_select_n |=> !data_oe)
        else $error("drive while deselected");
    AST_FLASH_ROUTE: assert property (!cur.pins.flash_select_n
        |-> acc.section == MEM_FLASH)
        else $error("flash not routed");
    AST_LOC: assert property (acc.loc == cur.pins.addr_lines[2:0])
        else $error("location mismatch");
    AST_GLYPH_ADDR: assert property (cur.pins.flash_select_n
        && cur.pins.addr_lines[4:3] == 2'h0 |-> acc.section == MEM_GLYPH_ADDR)
        else $error("glyph addr decode");
    AST_GLYPH_RAM: assert property (cur.pins.flash_select_n
        && cur.pins.addr_lines[4:3] == 2'h1 |-> acc.section == MEM_GLYPH_RAM)
        else $error("glyph ram decode");
    AST_CONTROL: assert property (cur.pins.flash_select_n
        && cur.pins.addr_lines[4:3] == 2'h2 |-> acc.section == MEM_CONTROL)
        else $error("control decode");
    AST_CHAR: assert property (cur.pins.flash_select_n
        && cur.pins.addr_lines[4:3] == 2'h3 |-> acc.section == MEM_CHAR_RAM)
        else $error("char decode");
    AST_CTRL_WRITE: assert property ((s_write_first ##0 acc.section == MEM_CONTROL)
        |=> cur.control == $past(cur.pins.data))
        else $error("control write lost");
    AST_CHAR_WRITE: assert property ((s_write_first ##0 acc.section == MEM_CHAR_RAM)
        |=> cur.char_ram[$past(acc.loc)] == $past(cur.pins.data))
        else $error("character write lost");
    // a strobe without select must leave char ram, control and flash ram untouched
    AST_NO_WRITE_DESEL: assert property (cur.pins.chip_select_n
        |=> $stable(cur.char_ram) && $stable(cur.control) && $stable(cur.flash_ram))
        else $error("write taken while deselected");
    AST_CLK_DIR: assert property (cur.src_sync[1] |=> master_clk_oe)
        else $error("clock pin not driven");
    AST_CLK_IN: assert property (!cur.src_sync[1] |=> !master_clk_oe && !master_clk_out)
        else $error("clock pin driven in external mode");

endmodule
`default_nettype wire

/* File: common/display_bus_pkg.sv */
// package: constants, section codes and carriers for the display host bus port
package display_bus_pkg;

    // ************************************************************
    // widths and counts
    // ************************************************************
    localparam int DATA_W      = 8;        // host data bus width
    localparam int ADDR_W      = 5;        // address lines, low three pick a word
    localparam int LOC_W       = 3;        // location / row field width
    localparam int SEC_LSB     = 3;        // upper address lines start here
    localparam int DEPTH       = 8;        // words per addressed memory
    localparam int CLK_DIV     = 8;        // master clock divider, half period in clk cycles
    localparam logic [7:0] RESET_DATA = 8'h00; // memory contents after reset

    // ************************************************************
    // section codes on the two upper address lines
    // ************************************************************
    localparam logic [1:0] SEC_GLYPH_ADDR = 2'h0; // user-glyph address register
    localparam logic [1:0] SEC_GLYPH_RAM  = 2'h1; // user-glyph ram rows
    localparam logic [1:0] SEC_CONTROL    = 2'h2; // control word register
    localparam logic [1:0] SEC_CHAR_RAM   = 2'h3; // character ram

    // decoded memory section, one-hot
    typedef enum logic [4:0] {
        MEM_FLASH      = 5'h01,
        MEM_GLYPH_ADDR = 5'h02,
        MEM_GLYPH_RAM  = 5'h04,
        MEM_CONTROL    = 5'h08,
        MEM_CHAR_RAM   = 5'h10
    } mem_section_t;

    // host pins after synchronisation
    typedef struct packed {
        logic              chip_select_n;
        logic              write_n;
        logic              read_n;
        logic              flash_select_n;
        logic [ADDR_W-1:0] addr_lines;
        logic [DATA_W-1:0] data;
    } host_pins_t;

    // one decoded access
    typedef struct packed {
        mem_section_t     section;
        logic [LOC_W-1:0] loc;
    } access_t;

endpackage

/* File: verilog/section_decode.sv */
// module: address decode into one of the five memory sections
`timescale 1ns/1ns
`default_nettype none
module section_decode
    import display_bus_pkg::*;
(
    input  wire logic              flash_select_n, // low selects flash ram
    input  wire logic [ADDR_W-1:0] addr_lines,     // host address
    output var  access_t           access          // decoded section and location
);

    // ************************************************************
    // decode
    // ************************************************************
    // pure combinational; caller feeds it registered pins and uses the result unregistered
    always_comb begin
        access.loc = addr_lines[LOC_W-1:0];
        if (!flash_select_n) begin
            access.section = MEM_FLASH;
        end else begin
            unique case (addr_lines[ADDR_W-1:SEC_LSB])
                SEC_GLYPH_ADDR: access.section = MEM_GLYPH_ADDR;
                SEC_GLYPH_RAM:  access.section = MEM_GLYPH_RAM;
                SEC_CONTROL:    access.section = MEM_CONTROL;
                SEC_CHAR_RAM:   access.section = MEM_CHAR_RAM;
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: test/host_model.sv */
// host processor model that runs whole cycles on the display port bus
`timescale 1ns/1ns
`default_nettype none
module host_model
    import display_bus_pkg::*;
(
    input  wire logic              clk,            // system clock
    input  wire logic [DATA_W-1:0] data_out,       // device read data
    input  wire logic              data_oe,        // device drives bus
    output logic                   chip_select_n,  // select, low active
    output logic                   write_n,        // write strobe, low active
    output logic                   read_n,         // read strobe, low active
    output logic                   flash_select_n, // low picks flash ram
    output logic      [ADDR_W-1:0] addr_lines,     // address to device
    output logic      [DATA_W-1:0] host_data,      // write data
    output logic                   host_oe         // high while host drives bus
);
    // ************************************************************
    // idle levels from time zero
    // ************************************************************
    initial begin
        chip_select_n  = 1'b1;
        write_n        = 1'b1;
        read_n         = 1'b1;
        flash_select_n = 1'b1;
        addr_lines     = '0;
        host_data      = 8'h00;
        host_oe        = 1'b0;
    end

    // ************************************************************
    // one bus cycle: address first, strobes held 5 edges, then gap
    // ************************************************************
    // address settles an edge before select, since a change under select corrupts ram
    task automatic access(input logic wr, input logic rd, input logic cs, input logic fsel,
                          input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                          output logic oe, output logic [DATA_W-1:0] q);
        @(posedge clk);
        flash_select_n <= fsel;
        addr_lines     <= a;
        host_data      <= d;
        host_oe        <= wr;
        @(posedge clk);
        chip_select_n  <= cs;
        write_n        <= ~wr;
        read_n         <= ~rd;
        repeat (5) @(posedge clk);
        // sampled at the same edge that ends the strobes
        oe = data_oe;
        q  = data_out;
        chip_select_n  <= 1'b1;
        write_n        <= 1'b1;
        read_n         <= 1'b1;
        host_oe        <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: test/display_host_bus_decode_tb.sv */
// testbench for the display host bus port: sections, refusals, clock pin
`timescale 1ns/1ns
`default_nettype none
module display_host_bus_decode_tb
    import display_bus_pkg::*;
;
    localparam int DIV_TB = 2;          // short master clock half period
    logic              clk = 1'b0;      // system clock
    logic              rst = 1'b1;      // synchronous reset
    logic              src_sel = 1'b1;  // clock source select
    logic              ext_clk = 1'b0;  // external clock source level
    logic [DATA_W-1:0] last_bus = 8'h00; // last bus level, for the float pattern
    logic              cs_n, wr_n, rd_n, flash_n, host_oe, data_oe;
    logic              mclk_out, mclk_oe, tick;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] host_data, data_out;
    logic [DATA_W-1:0] bus_level;      // resolved data bus
    logic              pin_level;      // resolved clock pin
    int                err_count = 0;
    int                samples_checked = 0;

    // floating bus shows a pattern that changes every cycle
    assign bus_level = data_oe ? data_out : host_oe ? host_data : ~last_bus;
    assign pin_level = mclk_oe ? mclk_out : ext_clk;
    always @(posedge clk) last_bus <= bus_level;
    initial forever #20 clk = ~clk;

    display_host_bus_decode #(.DIV(DIV_TB)) display_host_bus_decode_i (
        .clk(clk), .rst(rst), .chip_select_n(cs_n), .write_n(wr_n), .read_n(rd_n),
        .flash_select_n(flash_n), .addr_lines(addr), .data_in(bus_level), .data_out(data_out),
        .data_oe(data_oe), .clock_source_select(src_sel), .master_clk_in(pin_level),
        .master_clk_out(mclk_out), .master_clk_oe(mclk_oe), .master_tick(tick));
    host_model host_model_i (
        .clk(clk), .data_out(data_out), .data_oe(data_oe), .chip_select_n(cs_n),
        .write_n(wr_n), .read_n(rd_n), .flash_select_n(flash_n), .addr_lines(addr),
        .host_data(host_data), .host_oe(host_oe));

    // ************************************************************
    // compare and closing
    // ************************************************************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ************************************************************
    // every section, every location; registers keep the last write
    // ************************************************************
    task automatic test_sections;
        logic [1:0] codes [5];
        logic       oe;
        logic [7:0] q;
        logic [7:0] exp_q;
        codes = '{2'h0, SEC_GLYPH_ADDR, SEC_GLYPH_RAM, SEC_CONTROL, SEC_CHAR_RAM};
        for (int s = 0; s < 5; s++) begin
            for (int l = 0; l < DEPTH; l++) begin
                host_model_i.access(1'b1, 1'b0, 1'b0, s != 0, {codes[s], 3'(l)},
                                    8'(s * 8'h20 + l + 8'h01), oe, q);
            end
        end
        // flash read with upper lines flipped, which must not matter
        for (int s = 0; s < 5; s++) begin
            for (int l = 0; l < DEPTH; l++) begin
                host_model_i.access(1'b0, 1'b1, 1'b0, s != 0,
                                    {(s == 0) ? 2'h3 : codes[s], 3'(l)}, 8'h00, oe, q);
                check("read enable", oe, 8'h01);
                // single registers keep the last of their eight writes
                exp_q = 8'(s * 8'h20 + ((s == 1 || s == 3) ? 7 : l) + 8'h01);
                check("section data", q, exp_q);
            end
        end
    endtask

    // ************************************************************
    // strobes without select are ignored; bus released after a read
    // ************************************************************
    task automatic test_refuse;
        logic       oe;
        logic [7:0] q;
        host_model_i.access(1'b1, 1'b0, 1'b1, 1'b1, {SEC_CHAR_RAM, 3'h0}, 8'hA5, oe, q);
        host_model_i.access(1'b0, 1'b1, 1'b1, 1'b1, {SEC_CHAR_RAM, 3'h0}, 8'h00, oe, q);
        check("unselected read", oe, 8'h00);
        host_model_i.access(1'b0, 1'b1, 1'b0, 1'b1, {SEC_CHAR_RAM, 3'h0}, 8'h00, oe, q);
        check("unselected write", q, 8'h81);
        check("bus released", data_oe, 8'h00);
        check("idle read data", data_out, 8'h00);
    endtask

    // ************************************************************
    // internal source drives the pin, external source is followed
    // ************************************************************
    task automatic test_clock;
        int highs;
        int ticks;
        highs = 0;
        ticks = 0;
        // four whole periods, whatever the phase
        repeat (8 * DIV_TB) begin
            @(posedge clk);
            highs += int'(mclk_out === 1'b1);
            ticks += int'(tick === 1'b1);
        end
        check("pin driven", mclk_oe, 8'h01);
        check("high count", 8'(highs), 8'(4 * DIV_TB));
        check("internal ticks", 8'(ticks), 8'h04);
        src_sel <= 1'b0;
        repeat (6) @(posedge clk);
        check("pin released", mclk_oe, 8'h00);
        ticks = 0;
        for (int i = 0; i < 36; i++) begin
            ext_clk <= (i % 12) < 6;
            @(posedge clk);
            ticks += int'(tick === 1'b1);
        end
        check("external ticks", 8'(ticks), 8'h03);
        src_sel <= 1'b1;
    endtask

    // ************************************************************
    // reset in mid-run: drivers off, memories cleared
    // ************************************************************
    task automatic test_reset;
        logic       oe;
        logic [7:0] q;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        check("reset data drive", data_oe, 8'h00);
        check("reset clock pin", mclk_oe, 8'h00);
        check("reset tick", tick, 8'h00);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        host_model_i.access(1'b0, 1'b1, 1'b0, 1'b1, {SEC_CHAR_RAM, 3'h0}, 8'h00, oe, q);
        check("cleared read enable", oe, 8'h01);
        check("cleared char ram", q, RESET_DATA);
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (20) @(posedge clk);
        test_sections();
        test_refuse();
        test_clock();
        test_reset();
        end_sim();
    end
    initial begin
        #(40 * 20000);
        err_count++;
        end_sim();
    end
endmodule
`default_nettype wire
